// >>> aou_dac_model.sv
`timescale 1ns/1ns
module aou_dac_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// converter inputs
	input wire logic [15:0] code [4],
	input wire logic [3:0] load,
	// external clock request
	input wire logic ext_go,
	// converter levels and pin pull-down
	output logic [15:0] lvl [4],
	output logic pin_lo
);
	logic [1:0] lo_cnt; // cycles left holding the pin low
	// each converter latches its code on load, else keeps it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		for (int i = 0; i < 4; i++) begin
			if (!rst_n) lvl[i] <= 16'h8000;
			else if (load[i]) lvl[i] <= code[i];
		end
	end
	// external source: one falling edge, then release to pull-up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) lo_cnt <= 2'h0;
		else if (ext_go) lo_cnt <= 2'h3;
		else if (lo_cnt != 2'h0) lo_cnt <= lo_cnt - 2'h1;
	end
	assign pin_lo = lo_cnt != 2'h0;
endmodule // aou_dac_model

// >>> aou_oclk_pin.sv
`timescale 1ns/1ns
module aou_oclk_pin (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic initiator,
	input wire logic fire,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	// received clock
	output logic fall
);
	localparam int CW = $clog2(aou_pkg::PULSE_CYC + 1);
	localparam logic [CW-1:0] PULSE_LEN = CW'(aou_pkg::PULSE_CYC);

	// pulse length must fit the allowed window
	if (aou_pkg::PULSE_CYC > aou_pkg::PULSE_MAX_CYC || aou_pkg::PULSE_CYC < 1) begin : g_bad_pulse
		$error("initiator pulse length outside window");
	end

	logic sync1; // first stage, read by sync2 only
	logic sync2; // stable pin level
	logic sync3; // previous stable level
	logic [CW-1:0] pulse_cnt; // remaining low cycles

	// two-stage synchroniser plus history
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// one received clock per falling edge in target mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fall <= 1'b0;
		end else begin
			fall <= !initiator && sync3 && !sync2;
		end
	end

	// low pulse counter in initiator mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt <= '0;
		end else if (!initiator) begin
			pulse_cnt <= '0;
		end else if (fire) begin
			pulse_cnt <= PULSE_LEN;
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - CW'(1);
		end
	end

	// pin drive, registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe <= 1'b0;
			pin_out <= 1'b1;
		end else begin
			pin_oe <= initiator;
			pin_out <= !(initiator && (fire || pulse_cnt > CW'(1)));
		end
	end
endmodule // aou_oclk_pin

// >>> aou_pkg.sv
package aou_pkg;
	// channel count and code width
	localparam int NUM_CH = 4;
	localparam int CODE_W = 16;

	// register byte offsets
	localparam logic [7:0] OFS_BCR = 8'h00;
	localparam logic [7:0] OFS_CH0 = 8'h08;
	localparam logic [7:0] OFS_CH1 = 8'h0C;
	localparam logic [7:0] OFS_CH2 = 8'h10;
	localparam logic [7:0] OFS_CH3 = 8'h14;
	localparam logic [7:0] OFS_BOR = 8'h18;

	// reset values
	localparam logic [15:0] CODE_RST = 16'h8000;
	localparam logic [3:0] MASK_RST = 4'hF;
	localparam logic [1:0] RANGE_RST = 2'h0;

	// board_control_reg field positions
	localparam int BCR_BUF_EN = 0;
	localparam int BCR_SIMUL = 1;
	localparam int BCR_RATE_EN = 2;
	localparam int BCR_SW_CLK = 3;
	localparam int BCR_RANGE_LO = 4;
	localparam int BCR_TWOS = 6;

	// output span codes
	localparam logic [1:0] RANGE_10V = 2'h0;
	localparam logic [1:0] RANGE_5V = 2'h1;
	localparam logic [1:0] RANGE_2V5 = 2'h2;

	// buffered_ops_reg field positions
	localparam int BOR_MASK_LO = 0;
	localparam int BOR_INITIATOR = 4;
	localparam int BOR_CLK_EN = 5;
	localparam int BOR_CLK_READY = 6;
	localparam int BOR_SW_CLK = 7;
	localparam int BOR_CIRC = 8;
	localparam int BOR_FOLLOW_LO = 20;
	localparam int BOR_SEQ = 22;
	localparam int BOR_BURST = 23;

	// follow_adc_clock_field codes
	localparam logic [1:0] FOLLOW_OFF = 2'h0;
	localparam logic [1:0] FOLLOW_SAMPLE = 2'h1;
	localparam logic [1:0] FOLLOW_ACQ = 2'h2;

	// initiator low pulse timing
	localparam int CLK_NS = 20;
	localparam int PULSE_MIN_NS = 70;
	localparam int PULSE_MAX_NS = 150;
	localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;

	// buffered transfer states
	typedef enum logic [1:0] {
		AOU_IDLE = 2'b01,
		AOU_FETCH = 2'b10
	} aou_state_e;
endpackage

// >>> aou_update_ctrl.sv
// Function
// - buffered select picks register or buffer source
// - channel registers hold 16-bit code, upper ignored
// - span field, three ranges, widest after reset
// - immediate mode: write updates its channel
// - simultaneous mode: output clock updates all channels
// - clock from strobe, generator, pin, inputs
// - source chosen by enable, initiator, follow field
// - initiator drives pin low pulse per clock, only with follow field off
// - target mode: pin falling edge gives clock
// - generator ignored in target or follow modes
// - follow 1: clock at input sample rate
// - follow 2: one clock per acquired sample
// - follow field acts in both modes
// - active mask forms group; buffer forms frame
// - buffered codes offset binary or two's complement
// - open buffer discards values until empty
// - circular buffer recirculates values with end marker
// - buffered clock external or internal generator
// - simultaneous buffered: whole group per clock
// - sequential buffered: one channel per clock
// - continuous runs on; burst sends one frame
// - inactive channel keeps its last value
// - host buffer writes only when open
`timescale 1ns/1ns
module aou_update_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register access port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// clock sources, same clock domain
	input wire logic rate_c_tick,
	input wire logic adc_sample_tick,
	input wire logic adc_acq_tick,
	input wire logic burst_trigger,
	// output clock pin
	input wire logic oclk_pin_in,
	output logic oclk_pin_out,
	output logic oclk_pin_oe,
	// output buffer read side
	input wire logic buf_valid,
	input wire logic [15:0] buf_data,
	input wire logic buf_eof,
	output logic buf_ready,
	// circular write-back
	output logic recirc_valid,
	output logic [15:0] recirc_data,
	output logic recirc_eof,
	// host buffer write permission
	output logic host_buf_wr_allow,
	// converter side
	output logic [15:0] dac_code0,
	output logic [15:0] dac_code1,
	output logic [15:0] dac_code2,
	output logic [15:0] dac_code3,
	output logic [3:0] dac_load,
	output logic [1:0] dac_range
);
	localparam int N = aou_pkg::NUM_CH;

	// true when no active channel sits above ch
	function automatic logic is_last(input logic [3:0] mask, input logic [1:0] ch);
		logic [3:0] above;
		above = mask >> (3'(ch) + 3'd1);
		return above == 4'h0;
	endfunction

	// next active channel after ch, wrapping
	function automatic logic [1:0] next_active(input logic [3:0] mask, input logic [1:0] ch);
		logic [1:0] res;
		logic [1:0] idx;
		res = ch;
		for (int k = 3; k >= 1; k--) begin
			idx = ch + 2'(k);
			if (mask[idx]) begin
				res = idx;
			end
		end
		return res;
	endfunction

	// buffered code to offset binary
	function automatic logic [15:0] to_offset(input logic [15:0] v, input logic twos);
		return twos ? {~v[15], v[14:0]} : v;
	endfunction

	// board_control_reg fields
	logic buf_en; // buffered mode
	logic simul; // synchronous update
	logic rate_en; // internal generator enable
	logic [1:0] out_range; // output span
	logic twos; // two's complement coding
	// buffered_ops_reg fields
	logic [3:0] active_mask; // out_channel_active_bit group
	logic initiator; // clock driver select
	logic clk_en; // buffered clocking enable
	logic circ; // circular buffer
	logic [1:0] follow_adc_clock_field; // follow input rate
	logic seq; // sequential clocking
	logic burst; // triggered burst sampling
	// strobes and clocks
	logic sw_pulse; // one-cycle software strobe
	logic src_tick; // selected hardware source
	logic oclk; // output clock event
	logic pin_fall; // received pin edge
	// storage
	logic [15:0] ch_code [N]; // output_code_bits per channel
	logic [15:0] dac_q [N]; // converter codes
	logic [15:0] stage [N]; // group being assembled
	// buffered transfer
	aou_pkg::aou_state_e state;
	logic [1:0] ch_ptr; // channel of next value
	logic burst_armed; // frame pending in burst mode
	logic pop; // value taken this cycle
	logic [15:0] pop_code; // converted value
	logic grp_end; // value closes a group
	logic ch_hit [N]; // decoded channel address

	// channel register decode
	always_comb begin
		ch_hit[0] = reg_addr == aou_pkg::OFS_CH0;
		ch_hit[1] = reg_addr == aou_pkg::OFS_CH1;
		ch_hit[2] = reg_addr == aou_pkg::OFS_CH2;
		ch_hit[3] = reg_addr == aou_pkg::OFS_CH3;
	end

	// board_control_reg writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			buf_en <= 1'b0;
			simul <= 1'b0;
			rate_en <= 1'b0;
			out_range <= aou_pkg::RANGE_RST;
			twos <= 1'b0;
		end else if (reg_wr && reg_addr == aou_pkg::OFS_BCR) begin
			buf_en <= reg_wdata[aou_pkg::BCR_BUF_EN];
			simul <= reg_wdata[aou_pkg::BCR_SIMUL];
			rate_en <= reg_wdata[aou_pkg::BCR_RATE_EN];
			twos <= reg_wdata[aou_pkg::BCR_TWOS];
			// unused span code keeps the old span
			if (reg_wdata[aou_pkg::BCR_RANGE_LO +: 2] != 2'h3) begin
				out_range <= reg_wdata[aou_pkg::BCR_RANGE_LO +: 2];
			end
		end
	end

	// buffered_ops_reg writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active_mask <= aou_pkg::MASK_RST;
			initiator <= 1'b0;
			clk_en <= 1'b0;
			circ <= 1'b0;
			follow_adc_clock_field <= aou_pkg::FOLLOW_OFF;
			seq <= 1'b0;
			burst <= 1'b0;
		end else if (reg_wr && reg_addr == aou_pkg::OFS_BOR) begin
			active_mask <= reg_wdata[aou_pkg::BOR_MASK_LO +: 4];
			initiator <= reg_wdata[aou_pkg::BOR_INITIATOR];
			clk_en <= reg_wdata[aou_pkg::BOR_CLK_EN];
			circ <= reg_wdata[aou_pkg::BOR_CIRC];
			follow_adc_clock_field <= reg_wdata[aou_pkg::BOR_FOLLOW_LO +: 2];
			seq <= reg_wdata[aou_pkg::BOR_SEQ];
			burst <= reg_wdata[aou_pkg::BOR_BURST];
		end
	end

	// software strobe: set by either register, cleared next cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sw_pulse <= 1'b0;
		end else begin
			sw_pulse <= reg_wr && ((reg_addr == aou_pkg::OFS_BCR && reg_wdata[aou_pkg::BCR_SW_CLK])
				|| (reg_addr == aou_pkg::OFS_BOR && reg_wdata[aou_pkg::BOR_SW_CLK]));
		end
	end

	// output clock source select
	always_comb begin
		unique case (follow_adc_clock_field)
			aou_pkg::FOLLOW_SAMPLE: src_tick = adc_sample_tick;
			aou_pkg::FOLLOW_ACQ: src_tick = adc_acq_tick;
			aou_pkg::FOLLOW_OFF: src_tick = initiator ? (rate_en && rate_c_tick) : pin_fall;
			default: src_tick = 1'b0;
		endcase
	end

	// direct mode needs no clock enable; buffered mode does, except for the software strobe
	assign oclk = sw_pulse || (src_tick && (!buf_en || clk_en));

	// pin handling: drive pulses or receive edges
	aou_oclk_pin u_pin (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.initiator(initiator && follow_adc_clock_field == aou_pkg::FOLLOW_OFF),
		.fire(oclk),
		.pin_in(oclk_pin_in),
		.pin_out(oclk_pin_out),
		.pin_oe(oclk_pin_oe),
		.fall(pin_fall)
	);

	// channel data registers, low half kept
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				ch_code[i] <= aou_pkg::CODE_RST;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < N; i++) begin
				if (ch_hit[i]) begin
					ch_code[i] <= reg_wdata[15:0];
				end
			end
		end
	end

	// buffered value handling
	assign buf_ready = state == aou_pkg::AOU_FETCH;
	assign pop = buf_ready && buf_valid;
	assign pop_code = to_offset(buf_data, twos);
	assign grp_end = is_last(active_mask, ch_ptr);
	assign host_buf_wr_allow = !circ;

	// buffered transfer sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= aou_pkg::AOU_IDLE;
			ch_ptr <= 2'd0;
		end else if (!buf_en || active_mask == 4'h0) begin
			state <= aou_pkg::AOU_IDLE;
			ch_ptr <= next_active(active_mask, 2'd3);
		end else begin
			unique case (state)
				aou_pkg::AOU_IDLE: begin
					// a clock starts a group or a single value
					if (oclk && (!burst || burst_armed)) begin
						state <= aou_pkg::AOU_FETCH;
						if (!seq) begin
							ch_ptr <= next_active(active_mask, 2'd3);
						end else if (!active_mask[ch_ptr]) begin
							ch_ptr <= next_active(active_mask, ch_ptr);
						end
					end
				end
				aou_pkg::AOU_FETCH: begin
					if (!buf_valid) begin
						state <= aou_pkg::AOU_IDLE;
					end else begin
						ch_ptr <= next_active(active_mask, ch_ptr);
						if (seq || grp_end) begin
							state <= aou_pkg::AOU_IDLE;
						end
					end
				end
			endcase
		end
	end

	// burst frame arming and end of frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			burst_armed <= 1'b0;
		end else if (!burst) begin
			burst_armed <= 1'b0;
		end else if (burst_trigger) begin
			burst_armed <= 1'b1;
		end else if (pop && buf_eof && (seq || grp_end)) begin
			burst_armed <= 1'b0;
		end
	end

	// group staging for simultaneous buffered clocking
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				stage[i] <= aou_pkg::CODE_RST;
			end
		end else if (pop) begin
			stage[ch_ptr] <= pop_code;
		end
	end

	// circular write-back with end marker
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			recirc_valid <= 1'b0;
			recirc_data <= 16'h0000;
			recirc_eof <= 1'b0;
		end else begin
			recirc_valid <= pop && circ;
			recirc_data <= buf_data;
			recirc_eof <= buf_eof;
		end
	end

	// converter codes and load strobes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				dac_q[i] <= aou_pkg::CODE_RST;
			end
			dac_load <= 4'h0;
		end else begin
			dac_load <= 4'h0;
			if (buf_en) begin
				if (pop && seq) begin
					// single value straight to its channel
					dac_q[ch_ptr] <= pop_code;
					dac_load[ch_ptr] <= 1'b1;
				end else if (pop && grp_end) begin
					// whole group at once, active channels only
					for (int i = 0; i < N; i++) begin
						if (active_mask[i]) begin
							dac_q[i] <= (2'(i) == ch_ptr) ? pop_code : stage[i];
						end
					end
					dac_load <= active_mask;
				end
			end else if (simul) begin
				// hold until an output clock, then all at once
				if (oclk) begin
					for (int i = 0; i < N; i++) begin
						dac_q[i] <= ch_code[i];
					end
					dac_load <= 4'hF;
				end
			end else begin
				// immediate: each write goes out on its own
				for (int i = 0; i < N; i++) begin
					if (reg_wr && ch_hit[i]) begin
						dac_q[i] <= reg_wdata[15:0];
						dac_load[i] <= 1'b1;
					end
				end
			end
		end
	end

	// source of converter codes follows the mode bit
	assign dac_code0 = dac_q[0];
	assign dac_code1 = dac_q[1];
	assign dac_code2 = dac_q[2];
	assign dac_code3 = dac_q[3];
	assign dac_range = out_range;

	// registered read data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= 32'h0000_0000;
			unique case (reg_addr)
				aou_pkg::OFS_BCR: begin
					reg_rdata[aou_pkg::BCR_BUF_EN] <= buf_en;
					reg_rdata[aou_pkg::BCR_SIMUL] <= simul;
					reg_rdata[aou_pkg::BCR_RATE_EN] <= rate_en;
					reg_rdata[aou_pkg::BCR_RANGE_LO +: 2] <= out_range;
					reg_rdata[aou_pkg::BCR_TWOS] <= twos;
				end
				aou_pkg::OFS_CH0: reg_rdata[15:0] <= ch_code[0];
				aou_pkg::OFS_CH1: reg_rdata[15:0] <= ch_code[1];
				aou_pkg::OFS_CH2: reg_rdata[15:0] <= ch_code[2];
				aou_pkg::OFS_CH3: reg_rdata[15:0] <= ch_code[3];
				aou_pkg::OFS_BOR: begin
					reg_rdata[aou_pkg::BOR_MASK_LO +: 4] <= active_mask;
					reg_rdata[aou_pkg::BOR_INITIATOR] <= initiator;
					reg_rdata[aou_pkg::BOR_CLK_EN] <= clk_en;
					reg_rdata[aou_pkg::BOR_CLK_READY] <= state == aou_pkg::AOU_IDLE;
					reg_rdata[aou_pkg::BOR_CIRC] <= circ;
					reg_rdata[aou_pkg::BOR_FOLLOW_LO +: 2] <= follow_adc_clock_field;
					reg_rdata[aou_pkg::BOR_SEQ] <= seq;
					reg_rdata[aou_pkg::BOR_BURST] <= burst;
				end
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // aou_update_ctrl

// >>> aou_update_ctrl_properties.sv
`timescale 1ns/1ns
module aou_update_ctrl_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	// clock sources and pin
	input wire logic adc_sample_tick,
	input wire logic adc_acq_tick,
	input wire logic oclk_pin_in,
	input wire logic oclk_pin_out,
	input wire logic oclk_pin_oe,
	// converter and buffer side
	input wire logic [15:0] dac_code0,
	input wire logic [3:0] dac_load,
	input wire logic [1:0] dac_range,
	input wire logic host_buf_wr_allow
);
	logic [1:0] sh_mode; // buffered and simultaneous bits
	logic [8:0] sh_bor; // low operations bits
	logic [1:0] sh_fol; // follow field
	logic dsim; // direct simultaneous mode
	logic bcr_wr;
	logic bor_wr;
	assign bcr_wr = reg_wr && reg_addr == aou_pkg::OFS_BCR;
	assign bor_wr = reg_wr && reg_addr == aou_pkg::OFS_BOR;
	assign dsim = sh_mode == 2'h2;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// shadow of mode bits from host writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_mode <= 2'h0;
		end else if (bcr_wr) begin
			sh_mode <= reg_wdata[1:0];
		end
	end
	// shadow of initiator, circular and follow
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_bor <= 9'h000;
			sh_fol <= 2'h0;
		end else if (bor_wr) begin
			sh_bor <= reg_wdata[8:0];
			sh_fol <= reg_wdata[21:20];
		end
	end
	a_code_hold: assert property (!dac_load[0] |-> $stable(dac_code0))
		else $error("channel code moved without load");
	a_imm_write: assert property (sh_mode == 2'h0 && reg_wr && reg_addr == aou_pkg::OFS_CH0
		|=> dac_code0 == $past(reg_wdata[15:0])) else $error("immediate write not applied");
	a_sim_all: assert property (dsim && dac_load != 4'h0 |-> dac_load == 4'hF)
		else $error("simultaneous load not on all channels");
	a_sw_strobe: assert property (bcr_wr && reg_wdata[3] && reg_wdata[1:0] == 2'h2
		|-> ##2 dac_load == 4'hF) else $error("software strobe gave no update");
	a_pin_pulse: assert property (oclk_pin_oe && $fell(oclk_pin_out)
		|-> !oclk_pin_out [*4] ##1 oclk_pin_out) else $error("pin pulse length wrong");
	a_target_fall: assert property (dsim && !sh_bor[4] && sh_fol == 2'h0 && $fell(oclk_pin_in)
		|-> ##[3:6] dac_load == 4'hF) else $error("pin fall gave no update");
	a_follow_sample: assert property (dsim && sh_fol == 2'h1 && adc_sample_tick
		|-> ##[1:2] dac_load == 4'hF) else $error("sample tick gave no update");
	a_follow_acq: assert property (dsim && sh_fol == 2'h2 && adc_acq_tick
		|-> ##[1:2] dac_load == 4'hF) else $error("acquisition tick gave no update");
	a_span_write: assert property (bcr_wr && reg_wdata[5:4] != 2'h3
		|=> dac_range == $past(reg_wdata[5:4])) else $error("span not taken");
	a_buf_allow: assert property (host_buf_wr_allow == !sh_bor[8])
		else $error("buffer write permission wrong");
endmodule // aou_update_ctrl_props

bind aou_update_ctrl aou_update_ctrl_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .adc_sample_tick(adc_sample_tick), .adc_acq_tick(adc_acq_tick),
	.oclk_pin_in(oclk_pin_in), .oclk_pin_out(oclk_pin_out), .oclk_pin_oe(oclk_pin_oe), .dac_code0(dac_code0),
	.dac_load(dac_load), .dac_range(dac_range), .host_buf_wr_allow(host_buf_wr_allow));

// >>> aou_update_ctrl_tb.sv
`timescale 1ns/1ns
module aou_update_ctrl_tb;
	// clock, reset and host port
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	// clock sources
	logic rate_c_tick = 1'b0;
	logic adc_sample_tick = 1'b0;
	logic adc_acq_tick = 1'b0;
	logic burst_trigger = 1'b0;
	// pin: design drive, else model pull-down, else pull-up
	logic pin_out, pin_oe, pin_lo;
	logic ext_go = 1'b0;
	wire pin_wire = pin_oe ? pin_out : !pin_lo;
	// buffer feed
	logic [15:0] bq [4];
	logic [2:0] bidx = 3'h0;
	logic [2:0] bn = 3'h0;
	wire buf_valid = bidx < bn;
	wire [15:0] buf_data = bq[bidx[1:0]];
	wire buf_eof = bidx + 3'h1 == bn;
	logic buf_ready, rc_v, rc_e, allow;
	logic [15:0] rc_d;
	// converter side
	logic [15:0] code [4];
	logic [15:0] lvl [4];
	logic [3:0] load;
	logic [1:0] rng;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int rcn = 0;
	logic [16:0] rlast = 17'h0_0000; // last write-back, eof and data
	int lowc = 0;

	aou_update_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rate_c_tick(rate_c_tick), .adc_sample_tick(adc_sample_tick),
		.adc_acq_tick(adc_acq_tick), .burst_trigger(burst_trigger), .oclk_pin_in(pin_wire), .oclk_pin_out(pin_out),
		.oclk_pin_oe(pin_oe), .buf_valid(buf_valid), .buf_data(buf_data), .buf_eof(buf_eof), .buf_ready(buf_ready),
		.recirc_valid(rc_v), .recirc_data(rc_d), .recirc_eof(rc_e), .host_buf_wr_allow(allow), .dac_code0(code[0]),
		.dac_code1(code[1]), .dac_code2(code[2]), .dac_code3(code[3]), .dac_load(load), .dac_range(rng));
	aou_dac_model dacs (.clk_sys(clk_sys), .rst_n(rst_n), .code(code), .load(load), .ext_go(ext_go), .lvl(lvl),
		.pin_lo(pin_lo));

	always #10 clk_sys = ~clk_sys;
	// watchdog, pops, write-backs and pin low cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (buf_valid && buf_ready) bidx <= bidx + 3'h1;
		if (rc_v) begin
			rcn <= rcn + 1;
			rlast <= {rc_e, rc_d};
		end
		if (pin_oe && !pin_out) lowc <= lowc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			close_out;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		#1 chk(reg_rdata, e);
	endtask
	// one-cycle pulse on a clock source, then settle
	task tick(input int k);
		@(posedge clk_sys);
		case (k)
			0: rate_c_tick <= 1'b1;
			1: adc_sample_tick <= 1'b1;
			default: adc_acq_tick <= 1'b1;
		endcase
		@(posedge clk_sys);
		{rate_c_tick, adc_sample_tick, adc_acq_tick} <= 3'h0;
		repeat (8) @(posedge clk_sys);
	endtask
	// channel writes with junk in the ignored upper half
	task codes(input logic [15:0] b);
		for (int i = 0; i < 4; i++) wr(aou_pkg::OFS_CH0 + 8'(4 * i), 32'hFFFF_0000 | 32'(b + 16'(i)));
		repeat (2) @(posedge clk_sys);
	endtask
	task lv(input logic [15:0] b);
		#1;
		for (int i = 0; i < 4; i++) chk(32'(lvl[i]), 32'(b + 16'(i)));
	endtask

	task t_reset;
		for (int i = 0; i < 4; i++) rd(aou_pkg::OFS_CH0 + 8'(4 * i), 32'h0000_8000);
		for (int i = 0; i < 4; i++) chk(32'(lvl[i]), 32'h0000_8000);
		rd(8'h40, 32'h0000_0000);
		chk(32'(rng), 32'h0000_0000);
	endtask
	task t_immediate;
		codes(16'h1110);
		lv(16'h1110);
		rd(aou_pkg::OFS_CH2, 32'h0000_1112);
	endtask
	task t_simul;
		wr(aou_pkg::OFS_BCR, 32'h0000_0002);
		codes(16'h2220);
		lv(16'h1110);
		wr(aou_pkg::OFS_BCR, 32'h0000_000A);
		repeat (3) @(posedge clk_sys);
		lv(16'h2220);
		rd(aou_pkg::OFS_BCR, 32'h0000_0002);
	endtask
	task t_initiator;
		wr(aou_pkg::OFS_BOR, 32'h0000_0010);
		wr(aou_pkg::OFS_BCR, 32'h0000_0006);
		codes(16'h3330);
		lowc = 0;
		tick(0);
		chk(lowc, 32'h0000_0004);
		lv(16'h3330);
	endtask
	task t_target;
		wr(aou_pkg::OFS_BOR, 32'h0000_0000);
		codes(16'h4440);
		tick(0);
		lv(16'h3330);
		@(posedge clk_sys);
		ext_go <= 1'b1;
		@(posedge clk_sys);
		ext_go <= 1'b0;
		repeat (10) @(posedge clk_sys);
		lv(16'h4440);
	endtask
	task t_follow;
		wr(aou_pkg::OFS_BOR, 32'h0010_0010);
		codes(16'h5550);
		tick(0);
		lv(16'h4440);
		tick(1);
		lv(16'h5550);
		wr(aou_pkg::OFS_BOR, 32'h0020_0000);
		codes(16'h6660);
		tick(1);
		lv(16'h5550);
		tick(2);
		lv(16'h6660);
	endtask
	task t_range;
		for (int r = 1; r < 4; r++) begin
			wr(aou_pkg::OFS_BCR, 32'(r) << 4);
			#1 chk(32'(rng), (r == 3) ? 32'h0000_0002 : 32'(r));
		end
	endtask
	task t_buffer;
		bq = '{16'h7770, 16'h7771, 16'h7772, 16'h0000};
		@(posedge clk_sys);
		bn <= 3'h2;
		wr(aou_pkg::OFS_BOR, 32'h0000_0123);
		#1 chk(32'(allow), 32'h0000_0000);
		wr(aou_pkg::OFS_BCR, 32'h0000_0003);
		wr(aou_pkg::OFS_BCR, 32'h0000_000B);
		repeat (6) @(posedge clk_sys);
		#1 chk({lvl[1], lvl[0]}, 32'h7771_7770);
		chk({lvl[3], lvl[2]}, 32'h6663_6662);
		chk(rcn, 32'h0000_0002);
		chk(32'(rlast), 32'h0001_7771);
		wr(aou_pkg::OFS_BOR, 32'h0040_0123);
		bn <= 3'h4;
		wr(aou_pkg::OFS_BCR, 32'h0000_004B);
		repeat (6) @(posedge clk_sys);
		#1 chk({lvl[1], lvl[0]}, 32'h7771_F772);
		wr(aou_pkg::OFS_BCR, 32'h0000_004B);
		repeat (6) @(posedge clk_sys);
		#1 chk(32'(lvl[1]), 32'h0000_8000);
		// burst: strobe ignored until a trigger arms one frame
		bn <= 3'h5;
		wr(aou_pkg::OFS_BOR, 32'h00C0_0123);
		wr(aou_pkg::OFS_BCR, 32'h0000_004B);
		repeat (6) @(posedge clk_sys);
		#1 chk(32'(lvl[0]), 32'h0000_F772);
		@(posedge clk_sys);
		burst_trigger <= 1'b1;
		@(posedge clk_sys);
		burst_trigger <= 1'b0;
		wr(aou_pkg::OFS_BCR, 32'h0000_004B);
		repeat (6) @(posedge clk_sys);
		#1 chk(32'(lvl[0]), 32'h0000_F770);
	endtask

	task close_out;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_immediate;
		t_simul;
		t_initiator;
		t_target;
		t_follow;
		t_range;
		t_buffer;
		close_out;
	end
endmodule // aou_update_ctrl_tb
